// [rtl/cev_pkg.sv]
// Package: constants and types of the core event controller
package cev_pkg;
  localparam int          NUM_SRC      = 16;
  localparam int          NUM_GP       = 9;
  localparam int          LVL_W        = 4;
  localparam int          ADDR_W       = 32;
  localparam int          STATE_W      = 32;
  localparam int          SEL_W        = 4;
  localparam logic [3:0]  LVL_EMU      = 4'h0;
  localparam logic [3:0]  LVL_RST      = 4'h1;
  localparam logic [3:0]  LVL_NMI      = 4'h2;
  localparam logic [3:0]  LVL_EXC      = 4'h3;
  localparam logic [3:0]  LVL_GP_FIRST = 4'h7;
  localparam logic [3:0]  LVL_GP_LAST  = 4'hF;
  localparam logic [3:0]  LVL_SW_FIRST = 4'hE;
  localparam logic [3:0]  LVL_NONE     = 4'hF;
  localparam logic [15:0] ACTIVE_RST   = 16'h0000;
  localparam logic [31:0] ADDR_RST     = 32'h0000_0000;
  localparam logic [3:0]  SEL_RST      = 4'h0;
  localparam logic [15:0] IDLE_CODE    = 16'h0000;
  localparam logic [15:0] IMPL_LEVELS  = 16'hFF8F;

  typedef enum logic [1:0] {
    CEV_IDLE = 2'b00,
    CEV_SAVE = 2'b01,
    CEV_RUN  = 2'b10
  } cev_state_t;

  // Default routing: source i goes to level 7 + (i mod 7)
  function automatic logic [3:0] cev_default_map(input int idx);
    cev_default_map = LVL_GP_FIRST + 4'(idx % 7);
  endfunction : cev_default_map
endpackage : cev_pkg

// [rtl/cev_core_event_controller.sv]
// Two-stage event controller: system mapping stage and core priority stage
// Notes on behaviour
// - Emulation event puts the processor into emulation mode, controlled from test port.
// - Reset event returns the whole processor to its reset state; here it raises core_reset and clears only the active set.
// - Nonmaskable event raised by watchdog expiry or the nonmaskable pin.
// - Exceptions are synchronous; faulting instruction is held before completion; hold_insn rises only while no emulation, reset or nonmaskable event is pending.
// - Interrupt events accepted asynchronously from pins, timers and peripherals.
// - Each event class has its own return address register and return instruction.
// - Any taken event except emulation and reset saves processor state onto the supervisor stack.
// - Peripheral requests pass the mapping stage, then the core priority stage.
// - Nine prioritised general levels 7 to 15 plus dedicated events.
// - Mapping starts at a default; assignment writes change routing and priority; writes of a level below 7 are ignored here.
// - Nesting allowed; higher priority always serviced before lower.
`timescale 1ns/1ps
module cev_core_event_controller
  import cev_pkg::*;
#(
  parameter int N_SRC = cev_pkg::NUM_SRC
) (
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  input  wire logic                      emu_req,
  input  wire logic                      sw_reset_req,
  input  wire logic                      wdog_expired,
  input  wire logic                      nmi_pin,
  input  wire logic                      exc_req,
  input  wire logic [N_SRC-1:0]          periph_irq,
  input  wire logic [1:0]                sw_irq,
  input  wire logic                      assign_we,
  input  wire logic [$clog2(N_SRC)-1:0]  assign_idx,
  input  wire logic [cev_pkg::LVL_W-1:0] assign_lvl,
  input  wire logic [cev_pkg::ADDR_W-1:0] pc_now,
  input  wire logic [cev_pkg::STATE_W-1:0] proc_state,
  input  wire logic                      rtn_valid,
  input  wire logic [cev_pkg::LVL_W-1:0] rtn_lvl,
  output logic                           emu_mode,
  output logic                           core_reset,
  output logic                           hold_insn,
  output logic                           event_take,
  output logic [cev_pkg::LVL_W-1:0]      event_lvl,
  output logic                           save_push,
  output logic [cev_pkg::STATE_W-1:0]    save_data,
  output logic [cev_pkg::ADDR_W-1:0]     resume_addr,
  output logic                           resume_valid,
  output logic [15:0]                    active_levels
);
  import cev_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Pins and peripherals are asynchronous: three stages, edge on agreement
  localparam int NA = N_SRC + 4;
  logic [NA-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
  wire  [NA-1:0] raw_in = {periph_irq, sw_irq, emu_req, nmi_pin};
  wire  [NA-1:0] filt_next = (s2_reg == s3_reg) ? s2_reg : filt_reg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg   <= raw_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  wire              nmi_sync  = filt_reg[0];
  wire              emu_sync  = filt_reg[1];
  wire [1:0]        sw_sync   = filt_reg[3:2];
  wire [N_SRC-1:0]  irq_sync  = filt_reg[NA-1:4];

  // ----------------------------------------------------------------
  // System mapping stage
  // ----------------------------------------------------------------
  logic [LVL_W-1:0] map_reg [N_SRC];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < N_SRC; i++) map_reg[i] <= cev_default_map(i);
    end else if (assign_we && assign_lvl >= LVL_GP_FIRST) begin
      map_reg[assign_idx] <= assign_lvl;
    end
  end

  // Route sources onto levels; software levels also fed from sw_irq
  logic [15:0] gp_pend;
  always_comb begin
    gp_pend = '0;
    for (int i = 0; i < N_SRC; i++)
      if (irq_sync[i]) gp_pend[map_reg[i]] = 1'b1;
    gp_pend[LVL_SW_FIRST]     = gp_pend[LVL_SW_FIRST] | sw_sync[0];
    gp_pend[LVL_SW_FIRST + 1] = gp_pend[LVL_SW_FIRST + 1] | sw_sync[1];
  end

  // ----------------------------------------------------------------
  // Core priority stage
  // ----------------------------------------------------------------
  wire [15:0] pend = {gp_pend[15:7], 3'b000, exc_req,
                      nmi_sync | wdog_expired, sw_reset_req, emu_sync} & IMPL_LEVELS;

  function automatic logic [4:0] lowest_set(input logic [15:0] v);
    lowest_set = 5'h10;
    for (int k = 15; k >= 0; k--) if (v[k]) lowest_set = 5'(k);
  endfunction : lowest_set

  logic [15:0]       act_reg;
  logic [ADDR_W-1:0] ret_reg [16];
  cev_state_t        st_reg;
  logic [LVL_W-1:0]  lvl_reg;

  wire [4:0] pend_top = lowest_set(pend);
  wire [4:0] act_top  = lowest_set(act_reg);
  // Only strictly higher priority nests; equal level waits for return
  wire       preempt  = (pend_top < act_top) && st_reg != CEV_SAVE;
  wire [3:0] new_lvl  = pend_top[3:0];
  wire       rtn_ok   = rtn_valid && act_reg[rtn_lvl];
  wire       exc_now  = exc_req && (pend_top == {1'b0, LVL_EXC});

  wire        in_live  = (st_reg == CEV_IDLE) || (st_reg == CEV_RUN);
  wire        take_now = preempt && in_live;
  // Take beats return in one cycle; no return is taken during the save
  wire        rtn_now  = rtn_ok && !preempt && in_live;
  wire        save_now = (st_reg == CEV_SAVE);
  // Reset and emulation do not push state
  wire        push_now = save_now && (lvl_reg > LVL_RST);
  wire        rst_done = save_now && (lvl_reg == LVL_RST);
  wire [15:0] act_left = act_reg & ~(16'h1 << rtn_lvl);

  // ----------------------------------------------------------------
  // Event state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_reg  <= CEV_IDLE;
      lvl_reg <= LVL_NONE;
    end else begin
      case (st_reg)
        CEV_IDLE, CEV_RUN: begin
          if (take_now) begin
            st_reg  <= CEV_SAVE;
            lvl_reg <= new_lvl;
          end else if (rtn_now) begin
            st_reg <= (act_left == '0) ? CEV_IDLE : CEV_RUN;
          end
        end
        CEV_SAVE: st_reg <= CEV_RUN;
        default:  st_reg <= CEV_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Active set and return addresses
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      act_reg <= ACTIVE_RST;
    end else if (take_now) begin
      act_reg[new_lvl] <= 1'b1;
    end else if (rtn_now) begin
      act_reg[rtn_lvl] <= 1'b0;
    end else if (rst_done) begin
      act_reg <= ACTIVE_RST;
    end
  end

  // One slot per level, so nested handlers never overwrite each other
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) ret_reg[i] <= ADDR_RST;
    end else if (take_now) begin
      ret_reg[new_lvl] <= pc_now;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      event_take   <= 1'b0;
      event_lvl    <= LVL_NONE;
      save_push    <= 1'b0;
      save_data    <= '0;
      resume_valid <= 1'b0;
      resume_addr  <= ADDR_RST;
    end else begin
      event_take   <= take_now;
      save_push    <= push_now;
      resume_valid <= rtn_now;
      if (take_now) begin
        event_lvl <= new_lvl;
      end
      if (push_now) begin
        save_data <= proc_state;
      end
      if (rtn_now) begin
        resume_addr <= ret_reg[rtn_lvl];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      emu_mode      <= 1'b0;
      core_reset    <= 1'b0;
      hold_insn     <= 1'b0;
      active_levels <= ACTIVE_RST;
    end else begin
      hold_insn     <= exc_now;
      core_reset    <= pend[LVL_RST];
      active_levels <= act_reg;
      if (take_now && new_lvl == LVL_EMU) begin
        emu_mode <= 1'b1;
      end else if (rtn_now && rtn_lvl == LVL_EMU) begin
        emu_mode <= 1'b0;
      end
    end
  end
endmodule : cev_core_event_controller

// [verification/cev_ctl_asserts.sv]
// Checker of the event controller ports
`timescale 1ns/1ps
module cev_ctl_chk import cev_pkg::*; (
  input wire logic        mclk, resetn, emu_req, sw_reset_req, wdog_expired, exc_req,
  input wire logic        rtn_valid, emu_mode, core_reset, hold_insn, event_take,
  input wire logic        save_push, resume_valid,
  input wire logic [3:0]  event_lvl,
  input wire logic [15:0] active_levels
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  emu_enter_a: assert property (emu_req [*5] |=> emu_mode)
    else $error("emulation mode not entered");
  core_rst_a: assert property (sw_reset_req |=> core_reset)
    else $error("core reset late");
  // Higher events would legitimately delay the nonmaskable one
  nmi_wdog_a: assert property (wdog_expired && !emu_mode && !core_reset
    |-> ##[1:8] active_levels[2]) else $error("nonmaskable not raised");
  exc_hold_a: assert property (hold_insn |-> $past(exc_req))
    else $error("hold without exception");
  resume_src_a: assert property (resume_valid |-> $past(rtn_valid))
    else $error("resume without return");
  save_take_a: assert property (event_take && event_lvl > LVL_RST |=> save_push)
    else $error("state not saved");
  save_src_a: assert property (save_push |-> $past(event_take))
    else $error("save without take");
  take_lvl_a: assert property (event_take |-> IMPL_LEVELS[event_lvl])
    else $error("take of missing level");
  take_gap_a: assert property (event_take |=> !event_take)
    else $error("takes too close");
  cover property (event_take && event_lvl == LVL_GP_FIRST);
  cover property (resume_valid);
  cover property (hold_insn);
endmodule : cev_ctl_chk

bind cev_core_event_controller cev_ctl_chk cev_ctl_chk_inst (.*);

// [verification/cev_seq_model.sv]
// Sequencer-side model: program counter, state word and returns
`timescale 1ns/1ps
module cev_seq_model import cev_pkg::*; (
  input wire logic        mclk, resetn, event_take, resume_valid, rtn_en, slow,
  input wire logic [3:0]  event_lvl,
  output logic     [31:0] pc_now,
  output logic     [31:0] proc_state,
  output logic            rtn_valid,
  output logic     [3:0]  rtn_lvl
);
  logic [4:0] wait_reg;
  // Pc only moves after a return, so the saved value is unambiguous
  assign proc_state = ~pc_now;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pc_now <= 32'h0000_1000;
      wait_reg <= 5'h00;
      rtn_valid <= 1'b0;
      rtn_lvl <= LVL_NONE;
    end else begin
      rtn_valid <= 1'b0;
      if (resume_valid) pc_now <= pc_now + 32'h0000_0010;
      if (event_take) begin
        wait_reg <= slow ? 5'h10 : 5'h08;
        rtn_lvl <= event_lvl;
      end else if (wait_reg != 5'h00) begin
        wait_reg <= wait_reg - 5'h01;
        rtn_valid <= rtn_en && wait_reg == 5'h01;
      end
    end
  end
endmodule : cev_seq_model

// [verification/cev_core_event_controller_tb.sv]
// Self-checking bench of the core event controller
`timescale 1ns/1ps
module cev_core_event_controller_tb;
  import cev_pkg::*;
  logic mclk = 0, resetn = 0, emu_req = 0, sw_reset_req = 0, wdog_expired = 0, nmi_pin = 0;
  logic exc_req = 0, assign_we = 0, rtn_en = 0, slow = 0, rtn_valid, event_take, save_push;
  logic emu_mode, core_reset, hold_insn, resume_valid;
  logic [15:0] periph_irq = 0, active_levels;
  logic [1:0]  sw_irq = 0;
  logic [3:0]  assign_idx = 0, assign_lvl = 4'h7, event_lvl, rtn_lvl, lvl_exp;
  logic [31:0] pc_now, proc_state, save_data, resume_addr, pc_seen;
  int          error_cnt = 0, compares = 0, i, k, s;
  cev_core_event_controller cev_core_event_controller_inst (.*);
  cev_seq_model cev_seq_model_inst (.*);
  initial forever #10 mclk = ~mclk;
  initial begin
    #400us;
    error_cnt++;
    summarize();
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [3:0] exp_map(input int idx);
    return 4'h7 + 4'(idx % 7);
  endfunction : exp_map
  task automatic do_reset;
    resetn = 0;
    repeat (16) @(negedge mclk);
    resetn = 1;
  endtask : do_reset
  // Bounded wait for a take or a resume pulse
  task automatic wait_hi(input bit ret);
    k = 0;
    while ((ret ? resume_valid : event_take) !== 1'b1 && k < 40) begin
      @(negedge mclk);
      k++;
    end
    check("pulse", ret ? resume_valid : event_take, 1);
  endtask : wait_hi
  task automatic map(input logic [3:0] idx, lvl);
    assign_idx = idx;
    assign_lvl = lvl;
    assign_we = 1;
    @(negedge mclk);
    assign_we = 0;
  endtask : map
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial begin
    void'($urandom(32'hAC86));
    do_reset();
    check("idle lvl", event_lvl, LVL_NONE);
    check("idle act", active_levels, ACTIVE_RST);
    $display("reset test done");
    rtn_en = 1;
    for (i = 0; i < 8; i++) begin
      s = $urandom % 16;
      lvl_exp = exp_map(s);
      if (i >= 4) begin
        lvl_exp = 4'h7 + 4'($urandom % 7);
        map(4'(s), lvl_exp);
        if (i == 7) map(4'(s), 4'h3);
      end
      slow = i[0];
      pc_seen = pc_now;
      periph_irq[s] = 1;
      wait_hi(0);
      periph_irq[s] = 0;
      check("map lvl", event_lvl, lvl_exp);
      @(negedge mclk);
      check("push", save_push, 1);
      check("state", save_data, ~pc_seen);
      wait_hi(1);
      check("resume", resume_addr, pc_seen);
      repeat (6) @(negedge mclk);
    end
    $display("mapping test done");
    rtn_en = 0;
    sw_irq = 2'b10;
    wait_hi(0);
    check("sw lvl", event_lvl, LVL_GP_LAST);
    map(4'h0, 4'h7);
    periph_irq[0] = 1;
    wait_hi(0);
    check("nest lvl", event_lvl, LVL_GP_FIRST);
    sw_irq = 2'b11;
    repeat (10) @(negedge mclk);
    check("no preempt", active_levels, 16'h8080);
    periph_irq = 0;
    sw_irq = 0;
    do_reset();
    $display("nesting test done");
    for (i = 0; i < 3; i++) begin
      {wdog_expired, nmi_pin, exc_req} = 3'b100 >> i;
      wait_hi(0);
      check("event lvl", event_lvl, i == 2 ? LVL_EXC : LVL_NMI);
      check("hold", hold_insn, i == 2);
      {wdog_expired, nmi_pin, exc_req} = 3'b000;
      do_reset();
    end
    sw_reset_req = 1;
    repeat (2) @(negedge mclk);
    check("core rst", core_reset, 1);
    sw_reset_req = 0;
    emu_req = 1;
    repeat (6) @(negedge mclk);
    check("emu", emu_mode, 1);
    emu_req = 0;
    $display("dedicated events test done");
    summarize();
  end
endmodule : cev_core_event_controller_tb
